// ===== mbdc_frame_ram.sv
// Frame buffer: one write port, registered read port
`timescale 1ns/1ps
module mbdc_frame_ram #(
	parameter int DEPTH = 256,
	parameter int AW = 8
) (
	input logic clk,
	input logic we,
	input logic [AW-1:0] waddr,
	input logic [7:0] wdata,
	input logic [AW-1:0] raddr,
	output logic [7:0] rdata
);
	logic [7:0] mem [DEPTH];

	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	always_ff @(posedge clk) begin
		rdata <= mem[raddr];
	end
endmodule : mbdc_frame_ram

// ===== mbdc_func_handler.sv
// Slave function handler with diagnostic and event counters
`timescale 1ns/1ps
module mbdc_func_handler
	import mbdc_pkg::*;
(
	input logic clk,
	input logic rst,
	input logic [7:0] my_addr,
	input logic cfg_changed,
	input mbdc_rx_byte_t rx_byte,
	input logic rx_end,
	input logic rx_char_err,
	input logic rx_overrun,
	output logic [7:0] tx_data,
	output logic tx_valid,
	input logic tx_ready,
	output logic hr_req_valid,
	output mbdc_hr_req_t hr_req,
	input mbdc_hr_rsp_t hr_rsp,
	output mbdc_dt_t dt_out
);
	typedef enum logic [3:0] {
		ST_RX, ST_DEC, ST_LD, ST_LDW, ST_ACT, ST_WAIT, ST_EXC,
		ST_POKE, ST_FIN, ST_TXR, ST_TXL, ST_TXW, ST_TXC
	} mbdc_state_t;

	function automatic logic [15:0] mbdc_crc_byte(input logic [15:0] c,
		input logic [7:0] b);
		logic [15:0] r;
		r = c ^ {8'h00, b};
		for (int i = 0; i < 8; i++) begin
			r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction : mbdc_crc_byte

	mbdc_state_t st_reg;
	logic [8:0] len_reg;
	logic ovf_reg, cerr_reg, orun_reg;
	logic [15:0] crc_reg, crcx_reg;
	logic [HDR_BYTES-1:0][7:0] hd_reg;
	logic [7:0] ptr_reg, end_reg, rlen_reg, pk_ptr_reg, exc_code_reg;
	logic half_reg, byte_mode_reg, loop_reg, exc_reg, cb_reg;
	logic [15:0] w_reg, ia_reg;
	logic [31:0] pk_reg;
	logic [2:0] pk_cnt_reg;
	logic [7:0] tx_data_reg;
	logic tx_valid_reg;
	logic [NUM_CNT-1:0][15:0] cnt_reg;
	logic [NUM_CNT-1:0] cnt_inc;
	logic [7:0] mem_rdata, mem_wdata, mem_waddr;
	logic mem_we;

	logic [7:0] fc, bc, wbc;
	logic [15:0] dsub, qty;
	logic [3:0] cidx;
	logic bcast, frame_seen, frame_ok, end_evt, clr_diag, clr_all;
	logic scat_ok, wm_ok;

	assign fc = hd_reg[1];
	assign bc = hd_reg[2];
	// Multiple write: byte count follows start address and quantity
	assign wbc = hd_reg[6];
	assign dsub = {hd_reg[2], hd_reg[3]};
	assign qty = {hd_reg[4], hd_reg[5]};
	assign cidx = 4'(dsub - DSUB_FIRST);
	assign bcast = hd_reg[0] == BCAST_ADDR;
	assign frame_seen = len_reg != 9'h000 || cerr_reg || orun_reg;
	assign frame_ok = !ovf_reg && !cerr_reg && !orun_reg
		&& len_reg >= FRAME_MIN && crc_reg == 16'h0000;
	assign end_evt = st_reg == ST_RX && rx_end && frame_seen;
	assign scat_ok = !bc[0] && bc >= SCAT_MIN_BC && bc <= SCAT_MAX_BC
		&& len_reg == {1'b0, bc} + SCAT_OVH;
	assign wm_ok = qty != 16'h0000 && qty <= WR_MAX_QTY
		&& {8'h00, wbc} == (qty << 1) && len_reg == {1'b0, wbc} + WM_OVH;
	assign clr_diag = st_reg == ST_DEC && fc == FC_DIAG && !bcast
		&& len_reg == LEN_FIXED && dsub == DSUB_CLEAR;
	assign clr_all = cfg_changed;

	// Counter events; messages being handled never overlap a new frame end
	always_comb begin
		cnt_inc = '0;
		cnt_inc[CI_BUS_MSG] = end_evt && frame_ok;
		cnt_inc[CI_COMM_ERR] = end_evt && !frame_ok;
		cnt_inc[CI_SLV_MSG] = end_evt && frame_ok
			&& (hd_reg[0] == my_addr || bcast);
		cnt_inc[CI_NO_RESP] = end_evt && frame_ok && bcast;
		cnt_inc[CI_OVERRUN] = end_evt && orun_reg;
		cnt_inc[CI_EXC] = st_reg == ST_EXC;
		cnt_inc[CI_NAK] = st_reg == ST_EXC && exc_code_reg == EXC_NAK;
		cnt_inc[CI_BUSY] = st_reg == ST_EXC && exc_code_reg == EXC_BUSY;
		cnt_inc[CI_EVENT] = st_reg == ST_FIN && !exc_reg && fc != FC_EVT_CNT;
	end

	// counters: an event in a clearing cycle still counts
	for (genvar g = 0; g < NUM_CNT; g++) begin : g_cnt
		always_ff @(posedge clk) begin
			if (rst) begin
				cnt_reg[g] <= CNT_RESET;
			end else if (clr_all || (clr_diag && g != CI_EVENT)) begin
				cnt_reg[g] <= CNT_RESET + {15'h0000, cnt_inc[g]};
			end else begin
				cnt_reg[g] <= cnt_reg[g] + {15'h0000, cnt_inc[g]};
			end
		end
	end

	// Buffer write: receive appends, later stages patch bytes in place
	always_comb begin
		mem_we = 1'b0;
		mem_waddr = len_reg[7:0];
		mem_wdata = rx_byte.data;
		if (st_reg == ST_RX) begin
			mem_we = rx_byte.valid && !rx_end && len_reg < FRAME_MAX;
		end else if (st_reg == ST_POKE) begin
			mem_we = 1'b1;
			mem_waddr = pk_ptr_reg;
			mem_wdata = pk_reg[31:24];
		end
	end

	mbdc_frame_ram #(.DEPTH(256), .AW(8)) u_ram (
		.clk(clk),
		.we(mem_we),
		.waddr(mem_waddr),
		.wdata(mem_wdata),
		.raddr(ptr_reg),
		.rdata(mem_rdata)
	);

	// Receive side: length, header copy, error flags and running CRC
	always_ff @(posedge clk) begin
		if (rst) begin
			len_reg <= 9'h000;
			ovf_reg <= 1'b0;
			cerr_reg <= 1'b0;
			orun_reg <= 1'b0;
			crc_reg <= CRC_INIT;
			hd_reg <= '0;
		end else if (st_reg == ST_RX) begin
			if (rx_end) begin
				if (!(frame_ok && (hd_reg[0] == my_addr || bcast))) begin
					len_reg <= 9'h000;
				end
				ovf_reg <= 1'b0;
				cerr_reg <= 1'b0;
				orun_reg <= 1'b0;
				crc_reg <= CRC_INIT;
			end else begin
				cerr_reg <= cerr_reg || rx_char_err;
				orun_reg <= orun_reg || rx_overrun;
				if (rx_byte.valid) begin
					if (len_reg < FRAME_MAX) begin
						len_reg <= len_reg + 9'h001;
						crc_reg <= mbdc_crc_byte(crc_reg, rx_byte.data);
						if (len_reg < 9'(HDR_BYTES)) begin
							hd_reg[len_reg[2:0]] <= rx_byte.data;
						end
					end else begin
						ovf_reg <= 1'b1;
					end
				end
			end
		end else if (st_reg == ST_FIN && bcast
			|| st_reg == ST_TXC && tx_ready && cb_reg) begin
			len_reg <= 9'h000;
		end
	end

	// Command sequencer
	always_ff @(posedge clk) begin
		if (rst) begin
			st_reg <= ST_RX;
			ptr_reg <= 8'h00;
			end_reg <= 8'h00;
			rlen_reg <= 8'h00;
			pk_ptr_reg <= 8'h00;
			pk_reg <= 32'h00000000;
			pk_cnt_reg <= 3'h0;
			exc_code_reg <= 8'h00;
			half_reg <= 1'b0;
			byte_mode_reg <= 1'b0;
			loop_reg <= 1'b0;
			exc_reg <= 1'b0;
			cb_reg <= 1'b0;
			w_reg <= 16'h0000;
			ia_reg <= 16'h0000;
			crcx_reg <= CRC_INIT;
			tx_data_reg <= 8'h00;
			tx_valid_reg <= 1'b0;
			hr_req_valid <= 1'b0;
			hr_req <= '0;
			dt_out <= '0;
		end else begin
			dt_out.valid <= 1'b0;
			dt_out.last <= 1'b0;
			case (st_reg)
			ST_RX: begin
				if (rx_end && frame_ok && (hd_reg[0] == my_addr || bcast)) begin
					st_reg <= ST_DEC;
				end
			end
			ST_DEC: begin
				exc_reg <= 1'b0;
				loop_reg <= 1'b0;
				half_reg <= 1'b0;
				byte_mode_reg <= 1'b0;
				rlen_reg <= ECHO_LEN;
				st_reg <= ST_EXC;
				exc_code_reg <= EXC_ILL_FUNC;
				case (fc)
				FC_SCATTER: begin
					if (!bcast && hd_reg[3] == SUB_SCATTER) begin
						if (!scat_ok) begin
							exc_code_reg <= EXC_ILL_VAL;
						end else begin
							// txn byte kept, values overwrite addresses
							ptr_reg <= SCAT_DATA_POS;
							end_reg <= bc + 8'h02;
							rlen_reg <= bc + 8'h03;
							st_reg <= ST_LD;
						end
					end
				end
				FC_WR_ONE: begin
					if (len_reg != LEN_FIXED) begin
						exc_code_reg <= EXC_ILL_VAL;
					end else begin
						ia_reg <= {hd_reg[2], hd_reg[3]};
						w_reg <= {hd_reg[4], hd_reg[5]};
						ptr_reg <= 8'h01;
						end_reg <= 8'h00;
						st_reg <= ST_ACT;
					end
				end
				FC_WR_MULTI: begin
					if (!wm_ok) begin
						exc_code_reg <= EXC_ILL_VAL;
					end else begin
						ia_reg <= {hd_reg[2], hd_reg[3]};
						ptr_reg <= WM_DATA_POS;
						end_reg <= wbc + 8'h06;
						st_reg <= ST_LD;
					end
				end
				FC_DATETIME: begin
					if (hd_reg[2] == SUB_SET_DT) begin
						if (len_reg < LEN_DT_MIN) begin
							exc_code_reg <= EXC_ILL_VAL;
						end else begin
							// stream the date and time bytes out
							byte_mode_reg <= 1'b1;
							ptr_reg <= DT_DATA_POS;
							end_reg <= len_reg[7:0] - 8'h03;
							rlen_reg <= len_reg[7:0] - 8'h02;
							st_reg <= ST_LD;
						end
					end
				end
				FC_DIAG: begin
					if (bcast) begin
						exc_code_reg <= EXC_ILL_FUNC;
					end else if (len_reg != LEN_FIXED) begin
						exc_code_reg <= EXC_ILL_VAL;
					end else if (dsub == DSUB_CLEAR) begin
						st_reg <= ST_FIN;
					end else if (dsub >= DSUB_FIRST && dsub <= DSUB_LAST) begin
						pk_reg <= {cnt_reg[cidx[2:0]], 16'h0000};
						pk_ptr_reg <= CNT_POS;
						pk_cnt_reg <= 3'h2;
						st_reg <= ST_POKE;
					end
				end
				FC_EVT_CNT: begin
					if (bcast) begin
						exc_code_reg <= EXC_ILL_FUNC;
					end else if (len_reg != LEN_EVT) begin
						exc_code_reg <= EXC_ILL_VAL;
					end else begin
						pk_reg <= {EVT_STATUS, cnt_reg[CI_EVENT]};
						pk_ptr_reg <= EVT_POS;
						pk_cnt_reg <= 3'h4;
						st_reg <= ST_POKE;
					end
				end
				default: begin
				end
				endcase
			end
			ST_LD: begin
				st_reg <= ST_LDW;
			end
			ST_LDW: begin
				w_reg <= {w_reg[7:0], mem_rdata};
				ptr_reg <= ptr_reg + 8'h01;
				half_reg <= !half_reg && !byte_mode_reg;
				st_reg <= (half_reg || byte_mode_reg) ? ST_ACT : ST_LD;
			end
			ST_ACT: begin
				if (byte_mode_reg) begin
					dt_out.valid <= 1'b1;
					dt_out.last <= ptr_reg > end_reg;
					dt_out.data <= w_reg[7:0];
					st_reg <= (ptr_reg > end_reg) ? ST_FIN : ST_LD;
				end else begin
					// write strobes, reads in request order
					hr_req_valid <= 1'b1;
					hr_req.we <= fc != FC_SCATTER;
					hr_req.addr <= (fc == FC_SCATTER) ? w_reg : ia_reg;
					hr_req.wdata <= w_reg;
					st_reg <= ST_WAIT;
				end
			end
			ST_WAIT: begin
				if (hr_rsp.ack) begin
					hr_req_valid <= 1'b0;
					if (hr_rsp.status != 8'h00) begin
						exc_code_reg <= hr_rsp.status;
						st_reg <= ST_EXC;
					end else if (fc == FC_SCATTER) begin
						// value replaces its address in the buffer
						pk_reg <= {hr_rsp.rdata, 16'h0000};
						pk_ptr_reg <= ptr_reg - 8'h02;
						pk_cnt_reg <= 3'h2;
						loop_reg <= 1'b1;
						st_reg <= ST_POKE;
					end else begin
						ia_reg <= ia_reg + 16'h0001;
						st_reg <= (ptr_reg > end_reg) ? ST_FIN : ST_LD;
					end
				end
			end
			ST_EXC: begin
				pk_reg <= {fc | EXC_FLAG, exc_code_reg, 16'h0000};
				pk_ptr_reg <= EXC_POS;
				pk_cnt_reg <= 3'h2;
				rlen_reg <= EXC_LEN;
				exc_reg <= 1'b1;
				loop_reg <= 1'b0;
				st_reg <= ST_POKE;
			end
			ST_POKE: begin
				pk_reg <= {pk_reg[23:0], 8'h00};
				pk_ptr_reg <= pk_ptr_reg + 8'h01;
				pk_cnt_reg <= pk_cnt_reg - 3'h1;
				if (pk_cnt_reg == 3'h1) begin
					st_reg <= (loop_reg && ptr_reg <= end_reg) ? ST_LD : ST_FIN;
				end
			end
			ST_FIN: begin
				crcx_reg <= CRC_INIT;
				ptr_reg <= 8'h00;
				st_reg <= bcast ? ST_RX : ST_TXR;
			end
			ST_TXR: begin
				st_reg <= ST_TXL;
			end
			ST_TXL: begin
				tx_data_reg <= mem_rdata;
				tx_valid_reg <= 1'b1;
				crcx_reg <= mbdc_crc_byte(crcx_reg, mem_rdata);
				st_reg <= ST_TXW;
			end
			ST_TXW: begin
				if (tx_ready) begin
					if (ptr_reg == rlen_reg - 8'h01) begin
						tx_data_reg <= crcx_reg[7:0];
						cb_reg <= 1'b0;
						st_reg <= ST_TXC;
					end else begin
						tx_valid_reg <= 1'b0;
						ptr_reg <= ptr_reg + 8'h01;
						st_reg <= ST_TXR;
					end
				end
			end
			ST_TXC: begin
				if (tx_ready) begin
					if (!cb_reg) begin
						tx_data_reg <= crcx_reg[15:8];
						cb_reg <= 1'b1;
					end else begin
						tx_valid_reg <= 1'b0;
						st_reg <= ST_RX;
					end
				end
			end
			default: begin
				st_reg <= ST_RX;
			end
			endcase
		end
	end

	assign tx_data = tx_data_reg;
	assign tx_valid = tx_valid_reg;

	sequence s_bad_end;
		st_reg == ST_RX && rx_end && frame_seen && !frame_ok && !clr_all;
	endsequence
	sequence s_bcast_end;
		end_evt && frame_ok && bcast && !clr_all;
	endsequence
	sequence s_wr_one_go;
		st_reg == ST_DEC && fc == FC_WR_ONE && len_reg == LEN_FIXED;
	endsequence

	AST_CNT_WRAP: assert property (@(posedge clk) disable iff (rst)
		cnt_reg[CI_BUS_MSG] == 16'hFFFF && cnt_inc[CI_BUS_MSG] && !clr_all
		|=> cnt_reg[CI_BUS_MSG] == 16'h0000)
		else $error("counter did not wrap to zero");
	AST_DIAG_CLEAR: assert property (@(posedge clk) disable iff (rst)
		clr_diag && !cnt_inc[CI_SLV_MSG] |=> cnt_reg[CI_SLV_MSG] == 16'h0000)
		else $error("clear command left a counter set");
	AST_CFG_CLEAR: assert property (@(posedge clk) disable iff (rst)
		clr_all && cnt_inc == '0 |=> cnt_reg == '0)
		else $error("settings change did not clear counters");
	AST_BAD_CRC: assert property (@(posedge clk) disable iff (rst)
		s_bad_end |=> st_reg == ST_RX && cnt_reg[CI_COMM_ERR]
		== $past(cnt_reg[CI_COMM_ERR]) + 16'h0001)
		else $error("bad frame not dropped and counted");
	AST_TXN_ECHO: assert property (@(posedge clk) disable iff (rst)
		st_reg == ST_TXW && !exc_reg && fc == FC_SCATTER
		&& ptr_reg == TXN_POS |-> tx_data == hd_reg[4])
		else $error("transmission number not echoed");
	AST_EXC_CODE: assert property (@(posedge clk) disable iff (rst)
		st_reg == ST_TXW && exc_reg && ptr_reg == EXC_POS
		|-> tx_data == (hd_reg[1] | EXC_FLAG))
		else $error("exception function code wrong");
	AST_WR_ONE: assert property (@(posedge clk) disable iff (rst)
		s_wr_one_go |-> ##2 hr_req_valid && hr_req.we
		&& hr_req.addr == {hd_reg[2], hd_reg[3]}
		&& hr_req.wdata == {hd_reg[4], hd_reg[5]})
		else $error("single register write not issued");
	AST_BCAST_CNT: assert property (@(posedge clk) disable iff (rst)
		s_bcast_end |=> cnt_reg[CI_NO_RESP]
		== $past(cnt_reg[CI_NO_RESP]) + 16'h0001)
		else $error("broadcast not counted");
	AST_SCAT_LIMIT: assert property (@(posedge clk) disable iff (rst)
		st_reg == ST_DEC && fc == FC_SCATTER && !bcast
		&& hd_reg[3] == SUB_SCATTER && bc > SCAT_MAX_BC
		|=> st_reg == ST_EXC && exc_code_reg == EXC_ILL_VAL)
		else $error("oversized scattered read accepted");
	AST_CNT_RETURN: assert property (@(posedge clk) disable iff (rst)
		st_reg == ST_DEC && fc == FC_DIAG && !bcast && len_reg == LEN_FIXED
		&& dsub == DSUB_FIRST |=> pk_reg[31:16] == $past(cnt_reg[CI_BUS_MSG]))
		else $error("bus message counter not returned");
endmodule : mbdc_func_handler

// ===== mbdc_hr_model.sv
// Holding register bank answering the handler's register port
`timescale 1ns/1ps
module mbdc_hr_model
	import mbdc_pkg::*;
(
	input logic clk,
	input logic rst,
	input logic hr_req_valid,
	input mbdc_hr_req_t hr_req,
	input logic [7:0] status,
	output mbdc_hr_rsp_t hr_rsp
);
	logic [15:0] mem [256];
	logic [31:0] lf;
	logic busy;
	logic [1:0] wt;
	initial begin
		for (int i = 0; i < 256; i++)
			mem[i] = 16'hA5C3 ^ 16'(i * 257);
		hr_rsp = '0;
		busy = 1'b0;
		wt = 2'h0;
		lf = 32'h0000_0025;
	end
	// Read data turns over between answers, as on a released bus
	always @(posedge clk) begin
		hr_rsp.ack <= 1'b0;
		hr_rsp.rdata <= ~hr_rsp.rdata;
		lf <= {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
		if (rst) begin
			busy <= 1'b0;
		end else if (busy && wt == 2'h0) begin
			busy <= 1'b0;
			hr_rsp.ack <= 1'b1;
			hr_rsp.status <= status;
			hr_rsp.rdata <= mem[hr_req.addr[7:0]];
			if (hr_req.we && status == 8'h00)
				mem[hr_req.addr[7:0]] <= hr_req.wdata;
		end else if (busy) begin
			wt <= wt - 2'h1;
		end else if (hr_req_valid && !hr_rsp.ack) begin
			busy <= 1'b1;
			wt <= lf[1:0];
		end
	end
endmodule : mbdc_hr_model

// ===== mbdc_pkg.sv
// Constants and carrier types of the serial function handler with counters
package mbdc_pkg;

	// Function and subfunction codes
	localparam logic [7:0] FC_SCATTER = 8'h64;
	localparam logic [7:0] SUB_SCATTER = 8'h04;
	localparam logic [7:0] FC_WR_ONE = 8'h06;
	localparam logic [7:0] FC_WR_MULTI = 8'h10;
	localparam logic [7:0] FC_DATETIME = 8'h2B;
	localparam logic [7:0] SUB_SET_DT = 8'h10;
	localparam logic [7:0] FC_DIAG = 8'h08;
	localparam logic [7:0] FC_EVT_CNT = 8'h0B;
	localparam logic [15:0] DSUB_CLEAR = 16'h000A;
	localparam logic [15:0] DSUB_FIRST = 16'h000B;
	localparam logic [15:0] DSUB_LAST = 16'h0012;

	// Exception replies and broadcast address
	localparam logic [7:0] EXC_FLAG = 8'h80;
	localparam logic [7:0] EXC_ILL_FUNC = 8'h01;
	localparam logic [7:0] EXC_ILL_VAL = 8'h03;
	localparam logic [7:0] EXC_BUSY = 8'h06;
	localparam logic [7:0] EXC_NAK = 8'h07;
	localparam logic [7:0] BCAST_ADDR = 8'h00;

	// Frame limits and byte positions
	localparam int SCAT_MAX_REGS = 100;
	localparam int WR_MAX_REGS = 123;
	localparam logic [7:0] SCAT_MAX_BC = 8'(2 * SCAT_MAX_REGS + 2);
	localparam logic [7:0] SCAT_MIN_BC = 8'h04;
	localparam logic [15:0] WR_MAX_QTY = 16'(WR_MAX_REGS);
	localparam int HDR_BYTES = 7;
	localparam logic [8:0] FRAME_MAX = 9'h100;
	localparam logic [8:0] FRAME_MIN = 9'h004;
	localparam logic [8:0] LEN_FIXED = 9'h008;
	localparam logic [8:0] LEN_EVT = 9'h004;
	localparam logic [8:0] LEN_DT_MIN = 9'h006;
	localparam logic [8:0] SCAT_OVH = 9'h005;
	localparam logic [8:0] WM_OVH = 9'h009;
	localparam logic [7:0] SCAT_DATA_POS = 8'h05;
	localparam logic [7:0] WM_DATA_POS = 8'h07;
	localparam logic [7:0] DT_DATA_POS = 8'h03;
	localparam logic [7:0] TXN_POS = 8'h04;
	localparam logic [7:0] CNT_POS = 8'h04;
	localparam logic [7:0] EVT_POS = 8'h02;
	localparam logic [7:0] EXC_POS = 8'h01;
	localparam logic [7:0] ECHO_LEN = 8'h06;
	localparam logic [7:0] EXC_LEN = 8'h03;
	localparam logic [15:0] EVT_STATUS = 16'h0000;

	// CRC16 of the serial line
	localparam logic [15:0] CRC_INIT = 16'hFFFF;
	localparam logic [15:0] CRC_POLY = 16'hA001;

	// Counters, in subfunction order; the event counter is last
	localparam int NUM_CNT = 9;
	localparam int CI_BUS_MSG = 0;
	localparam int CI_COMM_ERR = 1;
	localparam int CI_EXC = 2;
	localparam int CI_SLV_MSG = 3;
	localparam int CI_NO_RESP = 4;
	localparam int CI_NAK = 5;
	localparam int CI_BUSY = 6;
	localparam int CI_OVERRUN = 7;
	localparam int CI_EVENT = 8;
	localparam logic [15:0] CNT_RESET = 16'h0000;

	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} mbdc_rx_byte_t;

	typedef struct packed {
		logic we;
		logic [15:0] addr;
		logic [15:0] wdata;
	} mbdc_hr_req_t;

	typedef struct packed {
		logic ack;
		logic [7:0] status;
		logic [15:0] rdata;
	} mbdc_hr_rsp_t;

	typedef struct packed {
		logic valid;
		logic last;
		logic [7:0] data;
	} mbdc_dt_t;

endpackage : mbdc_pkg

// ===== tb.sv
// Self-checking bench of the function handler
`timescale 1ns/1ps
module tb;
	import mbdc_pkg::*;
	logic clk, rst, cfg_changed, rx_end, rx_char_err, rx_overrun;
	logic tx_valid, tx_ready, hr_req_valid;
	logic [7:0] my_addr, tx_data, st;
	mbdc_rx_byte_t rx_byte;
	mbdc_hr_req_t hr_req;
	mbdc_hr_rsp_t hr_rsp;
	mbdc_dt_t dt_out;
	logic [7:0] f[$], r[$], dq[$];
	logic [15:0] e[9];
	logic [31:0] x = 32'h0000_0025;
	int n_fail, n_compared, nlast;
	mbdc_func_handler dut_u (.clk(clk), .rst(rst), .my_addr(my_addr),
		.cfg_changed(cfg_changed), .rx_byte(rx_byte), .rx_end(rx_end),
		.rx_char_err(rx_char_err), .rx_overrun(rx_overrun),
		.tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
		.hr_req_valid(hr_req_valid), .hr_req(hr_req), .hr_rsp(hr_rsp),
		.dt_out(dt_out));
	mbdc_hr_model hr_u (.clk(clk), .rst(rst), .hr_req_valid(hr_req_valid),
		.hr_req(hr_req), .status(st), .hr_rsp(hr_rsp));
	function logic [7:0] rnd();
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x[7:0];
	endfunction : rnd
	function automatic logic [15:0] crc(input logic [7:0] q[$]);
		logic [15:0] c;
		c = CRC_INIT;
		foreach (q[i]) begin
			c ^= {8'h00, q[i]};
			for (int b = 0; b < 8; b++)
				c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
		end
		return c;
	endfunction : crc
	task automatic chk(input string n, input logic [15:0] ex, g);
		n_compared++;
		if (g !== ex) begin
			n_fail++;
			$display("BAD %s exp %h got %h", n, ex, g);
		end
	endtask : chk
	task automatic end_sim();
		$display("compared %0d mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : end_sim
	// Mode 1 spoils the CRC, 2 flags overrun, 3 flags a char error
	task automatic send(input int m);
		logic [15:0] c;
		c = crc(f) ^ 16'(m == 1);
		f.push_back(c[7:0]);
		f.push_back(c[15:8]);
		foreach (f[i]) begin
			rx_byte <= {1'b1, f[i]};
			rx_overrun <= m == 2 && i == 1;
			rx_char_err <= m == 3 && i == 1;
			@(posedge clk);
		end
		rx_byte <= '0;
		rx_overrun <= 1'b0;
		rx_char_err <= 1'b0;
		@(posedge clk);
		rx_end <= 1'b1;
		@(posedge clk);
		rx_end <= 1'b0;
		f.delete();
	endtask : send
	task automatic quiet();
		int s;
		s = 0;
		repeat (100) begin
			@(posedge clk);
			if (tx_valid !== 1'b0) s++;
		end
		chk("silent", 16'h0000, 16'(s));
	endtask : quiet
	task automatic reply();
		logic [15:0] c;
		int k;
		c = crc(r);
		r.push_back(c[7:0]);
		r.push_back(c[15:8]);
		k = 0;
		for (int t = 0; t < 9000 && k < r.size(); t++) begin
			@(posedge clk);
			if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
				chk("tx_data", {8'h00, r[k]}, {8'h00, tx_data});
				k++;
			end
			tx_ready <= rnd() > 8'h50;
		end
		chk("reply_len", 16'(r.size()), 16'(k));
		r.delete();
		quiet();
	endtask : reply
	task automatic rdc(input logic [7:0] sub, input int i);
		e[0]++;
		e[3]++;
		f = '{my_addr, FC_DIAG, 8'h00, sub, 8'h00, 8'h00};
		r = '{my_addr, FC_DIAG, 8'h00, sub, e[i][15:8], e[i][7:0]};
		send(0);
		reply();
		e[8]++;
	endtask : rdc
	task automatic rdall(input string n);
		for (int s = 0; s < 8; s++)
			rdc(DSUB_FIRST[7:0] + 8'(s), s);
		e[0]++;
		e[3]++;
		f = '{my_addr, FC_EVT_CNT};
		r = '{my_addr, FC_EVT_CNT, 8'h00, 8'h00, e[8][15:8], e[8][7:0]};
		send(0);
		reply();
		$display("done %s", n);
	endtask : rdall
	always @(posedge clk)
		if (dt_out.valid === 1'b1) begin
			dq.push_back(dt_out.data);
			if (dt_out.last === 1'b1) nlast = dq.size();
		end
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		#300000;
		n_fail++;
		end_sim();
	end
	initial begin
		logic [7:0] a, v, t, fc;
		logic [7:0] g[$];
		rst = 1'b1;
		cfg_changed = 1'b0;
		rx_byte = '0;
		rx_end = 1'b0;
		rx_char_err = 1'b0;
		rx_overrun = 1'b0;
		tx_ready = 1'b0;
		st = 8'h00;
		my_addr = (rnd() & 8'h7F) | 8'h01;
		foreach (e[i]) e[i] = 16'h0000;
		n_fail = 0;
		n_compared = 0;
		nlast = 0;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rdall("power_up");
		a = rnd();
		v = rnd();
		t = rnd();
		f = '{my_addr, FC_WR_ONE, 8'h00, a, v, 8'h3C};
		r = f;
		send(0);
		reply();
		f = '{my_addr, FC_WR_MULTI, 8'h00, a + 8'h1, 8'h00, 8'h02, 8'h04,
			8'h12, 8'h0A, 8'h74, 8'h0C};
		r = f[0:5];
		send(0);
		reply();
		f = '{my_addr, FC_SCATTER, 8'h08, SUB_SCATTER, t, 8'h00, a, 8'h00,
			a + 8'h2, 8'h00, a + 8'h1};
		r = '{my_addr, FC_SCATTER, 8'h08, SUB_SCATTER, t, v, 8'h3C, 8'h74,
			8'h0C, 8'h12, 8'h0A};
		send(0);
		reply();
		for (int n = 100; n < 102; n++) begin
			f = '{my_addr, FC_SCATTER, 8'(2 * n + 2), SUB_SCATTER, t};
			r = f;
			repeat (n) begin
				a = rnd();
				f.push_back(8'h00);
				f.push_back(a);
				r.push_back(hr_u.mem[a][15:8]);
				r.push_back(hr_u.mem[a][7:0]);
			end
			if (n > 100) r = '{my_addr, FC_SCATTER | EXC_FLAG, EXC_ILL_VAL};
			send(0);
			reply();
		end
		f = '{my_addr, FC_DATETIME, SUB_SET_DT, 8'h00, 8'h00, 8'h0E, 8'h0A,
			8'h02, 8'h0E, 8'h20, 8'h0D, 8'hAC};
		r = f;
		g = f[3:11];
		dq.delete();
		send(0);
		reply();
		chk("dt_last", 16'h0009, 16'(nlast));
		foreach (g[i]) chk("dt_data", {8'h00, g[i]}, {8'h00, dq[i]});
		e[0] += 6;
		e[2]++;
		e[3] += 6;
		e[8] += 5;
		$display("done transfers");
		// Broadcasts, foreign address and spoiled frames get no reply
		for (int k = 0; k < 6; k++) begin
			f = '{k == 2 ? my_addr + 8'h1 : k == 3 || k == 4 ? BCAST_ADDR :
				my_addr, k == 4 ? FC_DIAG : FC_WR_ONE, 8'h00, 8'h0B, 8'h00,
				8'h01};
			send(k < 2 ? k + 1 : k == 5 ? 3 : 0);
			quiet();
		end
		$display("done no_reply");
		e[0] += 3;
		e[1] += 3;
		e[2]++;
		e[3] += 2;
		e[4] += 2;
		e[7]++;
		e[8]++;
		// Unknown code, busy, nak, diag sub out of range, short write
		for (int k = 0; k < 5; k++) begin
			st <= k == 1 ? EXC_BUSY : k == 2 ? EXC_NAK : 8'h00;
			fc = k == 0 ? 8'h41 : k == 3 ? FC_DIAG : FC_WR_ONE;
			v = k == 1 ? EXC_BUSY : k == 2 ? EXC_NAK :
				k == 4 ? EXC_ILL_VAL : EXC_ILL_FUNC;
			f = '{my_addr, fc, 8'h00, 8'h05, 8'h00, 8'h07};
			if (k == 4) f.pop_back();
			r = '{my_addr, fc | EXC_FLAG, v};
			send(0);
			reply();
		end
		$display("done exceptions");
		st <= 8'h00;
		e[0] += 5;
		e[2] += 5;
		e[3] += 5;
		e[5]++;
		e[6]++;
		rdall("errors");
		f = '{my_addr, FC_DIAG, 8'h00, DSUB_CLEAR[7:0], 8'hA5, 8'h5A};
		r = f;
		send(0);
		reply();
		for (int i = 0; i < 8; i++) e[i] = 16'h0000;
		e[8]++;
		rdall("clear_cmd");
		cfg_changed <= 1'b1;
		@(posedge clk);
		cfg_changed <= 1'b0;
		@(posedge clk);
		foreach (e[i]) e[i] = 16'h0000;
		rdall("cfg_change");
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		foreach (e[i]) e[i] = 16'h0000;
		rdall("mid_reset");
		end_sim();
	end
endmodule : tb
